// >>> dv/sarc_ana_model.sv
// Analog core stand-in: comparator against a fixed level per input.
// Assumes a one-hot route and the trial code from the block.
`timescale 1ns/1ps
module sarc_ana_model (
    // Clock
    input wire i_sys_clk,
    // From the block
    input wire [4:0] i_route,
    input wire [9:0] i_trial,
    // Comparator answer
    output reg o_cmp
);
    reg tog_q = 1'b0;
    reg [9:0] lvl;
    integer k;
    // Unrouted sample has no level, so the answer keeps changing
    always @(posedge i_sys_clk) begin
        tog_q <= ~tog_q;
    end
    always @* begin
        lvl = 10'h0C3;
        for (k = 0; k < 5; k = k + 1) begin
            if (i_route[k]) begin
                lvl = 10'h0C3 + 10'h055 * k[9:0];
            end
        end
        o_cmp = (i_route == 5'h00) ? tog_q : (lvl >= i_trial);
    end
endmodule

// >>> dv/sarc_tb.sv
// Self-checking bench for the converter control block over its register bus.
// Assumes the analog core model and the bound port checker.
`timescale 1ns/1ps
`include "sarc_defines.vh"
module testbench;
    localparam [7:0] CSR = `SARC_ADDR_CSR;
    localparam [7:0] UPR = `SARC_ADDR_UPPER;
    localparam [7:0] LWR = `SARC_ADDR_LOWER;
    reg i_sys_clk = 1'b0;
    reg i_rst = 1'b1;
    reg i_wb_cyc = 1'b0;
    reg i_wb_stb = 1'b0;
    reg i_wb_we = 1'b0;
    reg [7:0] i_wb_adr = 8'h00;
    reg [7:0] i_wb_dat = 8'h00;
    reg i_wait_mode = 1'b0;
    reg i_halt_mode = 1'b0;
    reg i_wb_sel = 1'b0;
    reg sel_on = 1'b1;
    wire i_cmp_high, o_wb_ack, o_sample, o_analog_enable, o_settled, o_irq;
    wire [7:0] o_wb_dat;
    wire [4:0] o_input_route;
    wire [9:0] o_trial_code;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int t1, t2, t4;
    reg [7:0] q;
    reg [9:0] e;
    sarc_top #(.SETTLE_CYC(5)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_wait_mode(i_wait_mode), .i_halt_mode(i_halt_mode), .i_cmp_high(i_cmp_high),
        .o_input_route(o_input_route), .o_sample(o_sample), .o_trial_code(o_trial_code),
        .o_analog_enable(o_analog_enable), .o_settled(o_settled), .o_irq(o_irq));
    sarc_ana_model u_ana (.i_sys_clk(i_sys_clk), .i_route(o_input_route),
        .i_trial(o_trial_code), .o_cmp(i_cmp_high));
    always #10 i_sys_clk = ~i_sys_clk;
    // ========================================
    // Timeout and closing
    always @(posedge i_sys_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_errors++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ========================================
    // Bus and compare tasks
    task automatic chk(input string nm, input [15:0] x, input [15:0] g);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Hang on a missing ack is cut by the cycle ceiling
    task automatic wb(input [7:0] a, input w, input [7:0] d);
        @(posedge i_sys_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_sel <= sel_on;
        i_wb_adr <= a;
        i_wb_dat <= d;
        @(posedge i_sys_clk);
        while (o_wb_ack !== 1'b1) @(posedge i_sys_clk);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
        i_wb_sel <= 1'b0;
    endtask
    task automatic wait_done(output int t);
        int t0;
        t0 = cyc_n;
        do wb(CSR, 1'b0, 8'h00); while (q[7] !== 1'b1);
        t = cyc_n - t0;
    endtask
    // ========================================
    // Sequence
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wb(CSR, 1'b0, 8'h00);
        chk("csr_reset", 8'h00, q);
        wb(UPR, 1'b0, 8'h00);
        chk("upper_reset", 8'h00, q);
        wb(LWR, 1'b0, 8'h00);
        chk("lower_reset", 8'h00, q);
        wb(8'h50, 1'b0, 8'h00);
        chk("unmapped", 8'h00, q);
        wb(LWR, 1'b1, 8'hFF);
        wb(LWR, 1'b0, 8'h00);
        chk("lower_slow", 8'h08, q);
        // Byte lane off: the write must be ignored
        sel_on = 1'b0;
        wb(LWR, 1'b1, 8'h00);
        sel_on = 1'b1;
        wb(LWR, 1'b0, 8'h00);
        chk("lower_unselected", 8'h08, q);
        wb(LWR, 1'b1, 8'h00);
        wb(`SARC_ADDR_IRQ_MASK, 1'b1, 8'h01);
        wb(CSR, 1'b1, 8'h60);
        repeat (2) @(posedge i_sys_clk);
        chk("sampling", 1, o_sample);
        wait_done(t1);
        chk("irq_raised", 1, o_irq);
        wb(`SARC_ADDR_IRQ_STATUS, 1'b0, 8'h00);
        chk("irq_status", 8'h01, q);
        repeat (2) @(posedge i_sys_clk);
        chk("irq_cleared", 0, o_irq);
        wb(CSR, 1'b1, 8'h20);
        wait_done(t2);
        wb(LWR, 1'b1, 8'h08);
        wb(CSR, 1'b1, 8'h60);
        wb(CSR, 1'b0, 8'h00);
        chk("done_cleared_wr", 8'h60, q);
        wait_done(t4);
        chk("div2_slower", 1, t2 > t1 + 8);
        chk("div4_slower", 1, t4 > t2 + 16);
        wb(LWR, 1'b1, 8'h00);
        i_wait_mode <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            e = 10'h0C3 + 10'h055 * k[9:0];
            wb(CSR, 1'b1, 8'h20 | k[7:0]);
            wb(CSR, 1'b0, 8'h00);
            chk("csr_readback", 8'h20 | k[7:0], q);
            chk("route", (k < 5) ? (16'h1 << k) : 16'h0, o_input_route);
            if (k < 5) begin
                wait_done(t1);
                wb(LWR, 1'b0, 8'h00);
                chk("lower_result", {14'h0, e[1:0]}, q);
                wb(UPR, 1'b0, 8'h00);
                chk("upper_result", e[9:2], q);
                wb(CSR, 1'b0, 8'h00);
                chk("done_cleared_rd", 8'h20 | k[7:0], q);
            end
        end
        i_wait_mode <= 1'b0;
        wb(CSR, 1'b1, 8'h20);
        i_halt_mode <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        chk("halt_enable", 0, o_analog_enable);
        chk("halt_route", 0, o_input_route);
        chk("halt_sample", 0, o_sample);
        i_halt_mode <= 1'b0;
        repeat (9) @(posedge i_sys_clk);
        chk("settled", 1, o_settled);
        wait_done(t1);
        wb(UPR, 1'b0, 8'h00);
        chk("upper_input0", 8'h30, q);
        wait_done(t1);
        wb(`SARC_ADDR_IRQ_MASK, 1'b1, 8'h00);
        repeat (3) @(posedge i_sys_clk);
        chk("irq_masked", 0, o_irq);
        // Reset in mid-run with nonzero registers
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wb(CSR, 1'b0, 8'h00);
        chk("csr_rereset", 8'h00, q);
        wb(UPR, 1'b0, 8'h00);
        chk("upper_rereset", 8'h00, q);
        wb(LWR, 1'b0, 8'h00);
        chk("lower_rereset", 8'h00, q);
        chk("enable_rereset", 0, o_analog_enable);
        stop_test;
    end
endmodule

// >>> dv/sarc_top_chk.sv
// Port checker for the converter control block.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/1ps
module sarc_top_chk #(
    parameter SETTLE_CYC = 5
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // Bus
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [7:0] o_wb_dat,
    input wire o_wb_ack,
    // Modes and core
    input wire i_wait_mode,
    input wire i_halt_mode,
    input wire [4:0] o_input_route,
    input wire o_analog_enable,
    input wire o_settled
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
    // ========================================
    // Assertions
    a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not acknowledged one cycle later");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge longer than one cycle");
    a_lower_zero: assert property (rd_req && i_wb_adr == 8'h36 |=>
        o_wb_dat[7:4] == 4'h0 && !o_wb_dat[2]) else $error("lower reserved bits set");
    a_unmapped_zero: assert property (rd_req && i_wb_adr == 8'h50 |=> o_wb_dat == 8'h00)
        else $error("unmapped read not zero");
    a_route_onehot: assert property ($onehot0(o_input_route))
        else $error("more than one input routed");
    a_route_off: assert property (!o_analog_enable && !$past(o_analog_enable) |->
        o_input_route == 5'h00) else $error("input routed while off");
    a_halt_off: assert property (i_halt_mode ##1 i_halt_mode |-> !o_analog_enable)
        else $error("converter powered in halt");
    a_wait_keeps: assert property ($rose(i_wait_mode) && o_analog_enable && !i_halt_mode
        |=> o_analog_enable) else $error("wait mode stopped converter");
    a_settle_wait: assert property ($fell(i_halt_mode) |-> !o_settled [*3])
        else $error("settled flagged too soon after halt");
endmodule
bind sarc_top sarc_top_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_wait_mode(i_wait_mode), .i_halt_mode(i_halt_mode), .o_input_route(o_input_route),
    .o_analog_enable(o_analog_enable), .o_settled(o_settled));

// >>> rtl/sarc_clkdiv.v
// Conversion clock tick generator: one-cycle pulses at sys/1, /2 or /4.
// Assumes one system clock; restart realigns the phase.
`timescale 1ns/1ps
`include "sarc_defines.vh"
module sarc_clkdiv (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // Control
    input wire i_restart,
    input wire [1:0] i_div_mask,
    // Tick
    output reg o_tick
);
    reg [1:0] cnt_q;
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 2'h0;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            cnt_q <= 2'h0;
            o_tick <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            o_tick <= ((cnt_q & i_div_mask) == i_div_mask);
        end
    end
endmodule

// >>> rtl/sarc_defines.vh
// Constants for the converter control block: register map, fields, timing.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef SARC_DEFINES_VH
`define SARC_DEFINES_VH

// ========================================
// Register byte addresses
`define SARC_ADDR_CSR 8'h34
`define SARC_ADDR_UPPER 8'h35
`define SARC_ADDR_LOWER 8'h36
`define SARC_ADDR_IRQ_STATUS 8'h37
`define SARC_ADDR_IRQ_MASK 8'h38
`define SARC_ADDR_WIDTH 8

// ========================================
// Field positions
`define SARC_CSR_DONE_BIT 7
`define SARC_CSR_CLKSEL_BIT 6
`define SARC_CSR_ON_BIT 5
`define SARC_CSR_CH_HI 2
`define SARC_LOWER_SLOW_BIT 3
`define SARC_RESET_BYTE 8'h00
`define SARC_ZERO_BYTE 8'h00
`define SARC_ZERO_RES 10'h000
`define SARC_ZERO_CH 3'h0
`define SARC_MAX_CH 3'h4
`define SARC_IRQ_DONE_BIT 0
`define SARC_IRQ_ABORT_BIT 1

// ========================================
// Conversion timing in conversion clock ticks
`define SARC_SAMPLE_TICKS 4'h3
`define SARC_BITS 4'hA
`define SARC_SAR_START 10'h200
`define SARC_CNT_W 4
`define SARC_ONE4 4'h1
`define SARC_ZERO4 4'h0

// ========================================
// Wake-up settle interval: 10 us at 50 MHz
`define SARC_SETTLE_US 10
`define SARC_CLK_MHZ 50
`define SARC_SETTLE_CYC (`SARC_SETTLE_US * `SARC_CLK_MHZ)
`define SARC_SETTLE_W 10

// ========================================
// Clock divider codes
`define SARC_DIV_1 2'h0
`define SARC_DIV_2 2'h1
`define SARC_DIV_4 2'h3
`endif

// >>> rtl/sarc_top.v
// Converter control logic: registers, channel routing, conversion sequencer.
// Assumes an external analog core answering a comparator bit per trial.
// Contract
// R1 - Channel change aborts conversion, clears done, converts new channel.
// R2 - Control write with converter on aborts, clears done, restarts.
// R3 - Converter-on bit 5 read/write; 0 stops, 1 runs conversions.
// R4 - Wait mode leaves conversions running unchanged.
// R5 - Halt disables converter; settle interval needed after wake-up.
// R6 - Done bit 7 set on completion; cleared by upper read or control write.
// R7 - Clock select bit 6 read/write, combined with slow-mode bit.
// R8 - Slow 0/sel 0 gives /2, slow 0/sel 1 gives /1, slow 1 gives /4.
// R9 - Channel codes 0 to 4 route analog inputs zero to four.
// R10 - Upper result register shows result bits 9 to 2.
// R11 - Lower register: result bits 1:0, slow bit 3, rest zero.
// R12 - Reset clears all three registers: converter off, input zero.
// R13 - Converter on means continuous back-to-back conversions.
// R14 - Software reads lower then upper for ten bits.
// R15 - Codes 5 to 7 route no analog input.
// R16 - Both result registers and done flag update on one edge.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sarc_defines.vh"
module sarc_top #(
    parameter SETTLE_CYC = `SARC_SETTLE_CYC
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // Wishbone slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [7:0] i_wb_dat,
    input wire i_wb_sel,
    output reg [7:0] o_wb_dat,
    output reg o_wb_ack,
    // Power modes
    input wire i_wait_mode,
    input wire i_halt_mode,
    // Analog core
    input wire i_cmp_high,
    output reg [4:0] o_input_route,
    output reg o_sample,
    output reg [9:0] o_trial_code,
    output reg o_analog_enable,
    output reg o_settled,
    // Interrupt
    output reg o_irq
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONVERT = 2'h2;

    // ========================================
    // Decoding
    function [4:0] route_of;
        input [2:0] ch;
        begin
            if (ch > `SARC_MAX_CH) begin
                route_of = 5'h00; // R15
            end else begin
                route_of = 5'h01 << ch; // R9
            end
        end
    endfunction

    function [1:0] div_of;
        input slow;
        input sel;
        begin
            if (slow) begin
                div_of = `SARC_DIV_4; // R8
            end else if (sel) begin
                div_of = `SARC_DIV_1; // R8
            end else begin
                div_of = `SARC_DIV_2; // R8
            end
        end
    endfunction

    // ========================================
    // Registers
    reg done_q;
    reg clksel_q;
    reg on_q;
    reg [2:0] ch_q;
    reg slow_q;
    reg [9:0] result_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    // Trial code is the output flop itself, so the comparator answers the current trial
    wire [9:0] sar_q = o_trial_code;
    reg [`SARC_SETTLE_W-1:0] settle_q;
    reg halt_q;

    wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wr = req & i_wb_we & i_wb_sel;
    wire rd = req & ~i_wb_we;
    wire wr_csr = wr & (i_wb_adr == `SARC_ADDR_CSR);
    wire wr_lower = wr & (i_wb_adr == `SARC_ADDR_LOWER);
    wire wr_mask = wr & (i_wb_adr == `SARC_ADDR_IRQ_MASK);
    wire rd_upper = rd & (i_wb_adr == `SARC_ADDR_UPPER);
    wire rd_stat = rd & (i_wb_adr == `SARC_ADDR_IRQ_STATUS);
    wire new_on = i_wb_dat[`SARC_CSR_ON_BIT];
    wire [2:0] new_ch = i_wb_dat[`SARC_CSR_CH_HI:0];
    // Halt gates the converter; wait mode is deliberately not looked at
    wire run = on_q & ~i_halt_mode; // R4 R5
    // Any control write restarts; a write with the bit off stops instead
    wire restart = wr_csr; // R1 R2
    wire [1:0] div_mask = div_of(slow_q, clksel_q);
    wire tick;

    sarc_clkdiv u_div (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_restart(restart | ~run),
        .i_div_mask(div_mask),
        .o_tick(tick)
    );

    // ========================================
    // Sequencer
    wire conv_done = run & ~restart & tick & (state_q == ST_CONVERT) &
        (cnt_q == `SARC_ONE4);
    wire [9:0] trial_bit = 10'h001 << (cnt_q - `SARC_ONE4);
    wire aborted = (state_q != ST_IDLE) & restart;

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= `SARC_ZERO4;
            o_trial_code <= `SARC_ZERO_RES;
        end else if (restart | ~run) begin
            state_q <= ST_IDLE; // R1 R2 R3
            cnt_q <= `SARC_ZERO4;
            o_trial_code <= `SARC_ZERO_RES;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_SAMPLE; // R13
                    cnt_q <= `SARC_SAMPLE_TICKS;
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (cnt_q == `SARC_ONE4) begin
                            state_q <= ST_CONVERT;
                            cnt_q <= `SARC_BITS;
                            o_trial_code <= `SARC_SAR_START;
                        end else begin
                            cnt_q <= cnt_q - `SARC_ONE4;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        if (cnt_q == `SARC_ONE4) begin
                            // Back to sampling at once: continuous mode
                            state_q <= ST_SAMPLE; // R13
                            cnt_q <= `SARC_SAMPLE_TICKS;
                        end else begin
                            cnt_q <= cnt_q - `SARC_ONE4;
                            o_trial_code <= (i_cmp_high ? sar_q : (sar_q & ~trial_bit)) |
                                (trial_bit >> 1);
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Register file
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            done_q <= 1'b0; // R12
            clksel_q <= 1'b0;
            on_q <= 1'b0;
            ch_q <= `SARC_ZERO_CH;
            slow_q <= 1'b0;
            result_q <= `SARC_ZERO_RES;
            irq_mask_q <= 2'h0;
            irq_stat_q <= 2'h0;
        end else begin
            if (wr_csr) begin
                clksel_q <= i_wb_dat[`SARC_CSR_CLKSEL_BIT]; // R7
                on_q <= new_on; // R3
                ch_q <= new_ch; // R9
            end
            if (wr_lower) begin
                slow_q <= i_wb_dat[`SARC_LOWER_SLOW_BIT]; // R11
            end
            if (wr_mask) begin
                irq_mask_q <= i_wb_dat[1:0];
            end
            // Completion cannot coincide with a control write, so no race
            if (conv_done) begin
                done_q <= 1'b1; // R6 R16
                result_q <= (i_cmp_high ? sar_q : (sar_q & ~trial_bit)); // R16
            end else if (wr_csr | rd_upper) begin
                done_q <= 1'b0; // R6
            end
            // Set beats read-clear
            irq_stat_q[`SARC_IRQ_DONE_BIT] <= conv_done |
                (irq_stat_q[`SARC_IRQ_DONE_BIT] & ~rd_stat);
            irq_stat_q[`SARC_IRQ_ABORT_BIT] <= aborted |
                (irq_stat_q[`SARC_IRQ_ABORT_BIT] & ~rd_stat);
        end
    end

    // ========================================
    // Bus answer, one cycle after request
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= `SARC_ZERO_BYTE;
        end else begin
            o_wb_ack <= req;
            if (rd & (i_wb_adr == `SARC_ADDR_CSR)) begin
                o_wb_dat <= {done_q, clksel_q, on_q, 2'h0, ch_q};
            end else if (rd_upper) begin
                o_wb_dat <= result_q[9:2]; // R10
            end else if (rd & (i_wb_adr == `SARC_ADDR_LOWER)) begin
                o_wb_dat <= {4'h0, slow_q, 1'b0, result_q[1:0]}; // R11
            end else if (rd_stat) begin
                o_wb_dat <= {6'h00, irq_stat_q};
            end else if (rd & (i_wb_adr == `SARC_ADDR_IRQ_MASK)) begin
                o_wb_dat <= {6'h00, irq_mask_q};
            end else begin
                o_wb_dat <= `SARC_ZERO_BYTE;
            end
        end
    end

    // ========================================
    // Settle counter after halt and analog outputs
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_q <= {`SARC_SETTLE_W{1'b0}};
            halt_q <= 1'b0;
            o_settled <= 1'b0;
            o_input_route <= 5'h00;
            o_sample <= 1'b0;
            o_analog_enable <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            halt_q <= i_halt_mode;
            // Settle restarts at halt exit; only flags, conversions not held
            if (halt_q & ~i_halt_mode) begin
                settle_q <= SETTLE_CYC[`SARC_SETTLE_W-1:0]; // R5
            end else if (settle_q != {`SARC_SETTLE_W{1'b0}}) begin
                settle_q <= settle_q - {{(`SARC_SETTLE_W-1){1'b0}}, 1'b1};
            end
            // Exit cycle itself is not settled: the count is only loaded now
            o_settled <= run & ~(halt_q & ~i_halt_mode) &
                (settle_q == {`SARC_SETTLE_W{1'b0}}); // R5
            o_input_route <= run ? route_of(ch_q) : 5'h00; // R9 R15
            o_sample <= run & (state_q == ST_SAMPLE);
            o_analog_enable <= run; // R3 R5
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule
